// ==== shared/rwd_map.svh ====
// Purpose: constants for the reset and window watchdog supervisor.
// Assumes: 20 MHz clock, synchronous active-low reset.
// Notes: times hold the printed figure, counts derive from them.
`ifndef RWD_MAP_SVH
`define RWD_MAP_SVH

// Clock
`define CLK_PERIOD_NS 50

// Dip filter, least time used so short glitches are rejected
`define DIP_FILTER_NS 2000
`define DIP_FILTER_CYC \
  ((`DIP_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Release delay, nominal
`define RELEASE_DELAY_US 8000
`define RELEASE_DELAY_CYC (`RELEASE_DELAY_US * 1000 / `CLK_PERIOD_NS)

// Sampling periods
`define SAM_FAST_US 500
`define SAM_SLOW_US 1000
`define SAM_FAST_CYC (`SAM_FAST_US * 1000 / `CLK_PERIOD_NS)
`define SAM_SLOW_CYC (`SAM_SLOW_US * 1000 / `CLK_PERIOD_NS)

// Ignore window and watchdog period, counted in sampling periods
`define IGN_FAST_US 32000
`define IGN_SLOW_US 64000
`define PER_FAST_US 32000
`define PER_SLOW_US 64000
`define IGN_FAST_TICKS (`IGN_FAST_US / `SAM_FAST_US)
`define IGN_SLOW_TICKS (`IGN_SLOW_US / `SAM_SLOW_US)
`define PER_FAST_TICKS (`PER_FAST_US / `SAM_FAST_US)
`define PER_SLOW_TICKS (`PER_SLOW_US / `SAM_SLOW_US)

// Kick history pattern: high, high, low, low (newest in bit 0)
`define KICK_PATTERN 4'hC

// Counter widths
`define CYC_W 18
`define TICK_W 8

`endif

// ==== shared/rwd_pkg.sv ====
// Purpose: types for the reset and window watchdog supervisor.
// Assumes: constants live in rwd_map.svh.
// Notes: one-hot watchdog states.
package rwd_pkg;

  // Watchdog sequencer states
  typedef enum logic [5:0] {
    wd_reset = 6'h01,
    wd_hold = 6'h02,
    wd_ignore = 6'h04,
    wd_trigger = 6'h08,
    wd_gap = 6'h10,
    wd_fault = 6'h20
  } wd_state_e;

  // Speed mode
  typedef enum logic {
    speed_fast = 1'b0,
    speed_slow = 1'b1
  } speed_e;

endpackage : rwd_pkg

// ==== src/reset_and_window_watchdog.sv ====
// Purpose: reset generator and window watchdog of a regulator supervisor.
// Assumes: analog comparator results arrive as synchronous levels.
// Notes: open-drain pins split into level, enable; enable high drives low.
// Notes: release delay, sampling periods shortened only by parameters.
// Notes: kick history cleared at each window start.
`timescale 1ns/1ps
`default_nettype none
`include "rwd_map.svh"

module reset_and_window_watchdog
  import rwd_pkg::*;
#(
  parameter int RELEASE_CYC = `RELEASE_DELAY_CYC,
  parameter int SAM_FAST_CYC = `SAM_FAST_CYC,
  parameter int SAM_SLOW_CYC = `SAM_SLOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Analog supervisor results
  input wire logic thresh_below,
  input wire logic vfb_below_1v,
  input wire logic vs_undervolt,
  // Processor side
  input wire logic wdog_kick_in,
  input wire logic wdog_speed_sel,
  // Reset output pin
  output logic reset_out_n_o,
  output logic reset_out_n_oe,
  // Watchdog fault output pin
  output logic wdog_fault_out_n_o,
  output logic wdog_fault_out_n_oe
);

  // Input synchronisers
  logic kick_meta;
  logic kick_sync;
  logic speed_meta;
  logic speed_sync;
  logic next_kick_meta;
  logic next_kick_sync;
  logic next_speed_meta;
  logic next_speed_sync;

  // Reset generator state
  logic [`CYC_W-1:0] dip_cnt;
  logic [`CYC_W-1:0] next_dip_cnt;
  logic dip_low;
  logic next_dip_low;
  logic rst_active;
  logic next_rst_active;
  logic [`CYC_W-1:0] rd_cnt;
  logic [`CYC_W-1:0] next_rd_cnt;
  logic reset_cond;

  // Watchdog state
  // Cycle counter restarts at every phase change, so one counter serves
  // hold, ignore, window, gap and fault timing
  wd_state_e state;
  wd_state_e next_state;
  speed_e mode;
  speed_e next_mode;
  logic [`CYC_W-1:0] cyc;
  logic [`CYC_W-1:0] next_cyc;
  logic [`TICK_W-1:0] ticks;
  logic [`TICK_W-1:0] next_ticks;
  logic [3:0] hist;
  logic [3:0] next_hist;
  logic sam_tick;
  logic rel_done;
  logic [`CYC_W-1:0] sam_last;
  logic [`TICK_W-1:0] ign_ticks;
  logic [`TICK_W-1:0] win_ticks;
  logic [3:0] hist_shift;

  // Pin registers
  // Only the enables move; the drive level is tied low because both pins
  // are open drain and must never push a high level
  logic next_reset_oe;
  logic next_fault_oe;

  // Two-flop synchronisers for processor pins
  // Processor edges are free running, so the first flop may go metastable;
  // only the second flop feeds decisions
  // Costs two cycles of latency, far below one sampling period
  // Reset value low matches the idle level of both pins
  always_comb begin
    next_kick_meta = wdog_kick_in;
    next_kick_sync = kick_meta;
    next_speed_meta = wdog_speed_sel;
    next_speed_sync = speed_meta;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      kick_meta <= 1'b0;
      kick_sync <= 1'b0;
      speed_meta <= 1'b0;
      speed_sync <= 1'b0;
    end else begin
      kick_meta <= next_kick_meta;
      kick_sync <= next_kick_sync;
      speed_meta <= next_speed_meta;
      speed_sync <= next_speed_sync;
    end
  end

  // Dip filter and reset delay
  // Counter runs while the sense comparator reports low
  // Any return above threshold clears it, so dips do not add up
  // Least filter time chosen: slower filters would let real faults
  // persist longer before the processor is held
  // The comparator already carries its hysteresis, so only time is judged
  always_comb begin
    next_dip_cnt = dip_cnt;
    next_dip_low = dip_low;
    if (!thresh_below) begin
      next_dip_cnt = '0;
      next_dip_low = 1'b0;
    end else if (dip_cnt >= `CYC_W'(`DIP_FILTER_CYC - 1)) begin
      next_dip_low = 1'b1;
    end else begin
      next_dip_cnt = dip_cnt + `CYC_W'(1);
    end
  end

  assign reset_cond = dip_low | vs_undervolt;

  // Reset held while the condition stands plus one release delay
  // A new condition during the delay restarts it from zero
  // Input undervoltage acts without filtering, as the supply is
  // already too low to trust the output
  // Power-on state is active, so the delay also covers start-up
  always_comb begin
    next_rst_active = rst_active;
    next_rd_cnt = rd_cnt;
    if (reset_cond) begin
      next_rst_active = 1'b1;
      next_rd_cnt = '0;
    end else if (rst_active) begin
      if (rd_cnt >= `CYC_W'(RELEASE_CYC - 1)) begin
        next_rst_active = 1'b0;
        next_rd_cnt = '0;
      end else begin
        next_rd_cnt = rd_cnt + `CYC_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dip_cnt <= '0;
      dip_low <= 1'b0;
      rst_active <= 1'b1;
      rd_cnt <= '0;
    end else begin
      dip_cnt <= next_dip_cnt;
      dip_low <= next_dip_low;
      rst_active <= next_rst_active;
      rd_cnt <= next_rd_cnt;
    end
  end

  // Time base of the latched mode
  // Mode is latched, never the live pin, so a mid-window change of
  // speed select cannot stretch or shrink the running window
  // Ignore and period figures are held in sampling ticks, which keeps
  // the tick counter narrow
  always_comb begin
    if (mode == speed_slow) begin
      sam_last = `CYC_W'(SAM_SLOW_CYC - 1);
      ign_ticks = `TICK_W'(`IGN_SLOW_TICKS);
      win_ticks = `TICK_W'(`PER_SLOW_TICKS - 1);
    end else begin
      sam_last = `CYC_W'(SAM_FAST_CYC - 1);
      ign_ticks = `TICK_W'(`IGN_FAST_TICKS);
      win_ticks = `TICK_W'(`PER_FAST_TICKS - 1);
    end
    sam_tick = (cyc == sam_last);
    rel_done = (cyc >= `CYC_W'(RELEASE_CYC - 1));
    hist_shift = {hist[2:0], kick_sync};
  end

  // Watchdog sequencer
  // Flow: reset, hold one release delay, ignore, then trigger windows
  // separated by a one-sample gap after each accepted kick
  // A missed window goes to fault for one release delay and back to
  // ignore, as after reset
  // Reset activity overrides everything below and parks in wd_reset
  // History is cleared at each window start, so a kick that straddles two
  // periods or falls in the gap never qualifies
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cyc = cyc + `CYC_W'(1);
    next_ticks = ticks;
    next_hist = hist;
    case (state)
      wd_reset: begin
        next_cyc = '0;
        if (!rst_active) begin
          next_state = wd_hold;
        end
      end
      wd_hold, wd_fault: begin
        if (rel_done) begin
          next_state = wd_ignore;
          next_cyc = '0;
          next_ticks = '0;
          next_mode = speed_e'(speed_sync);
        end
      end
      wd_ignore: begin
        // Kick input not looked at here
        if (sam_tick) begin
          next_cyc = '0;
          if (ticks == ign_ticks - `TICK_W'(1)) begin
            next_state = wd_trigger;
            next_ticks = '0;
            next_hist = '0;
            next_mode = speed_e'(speed_sync);
          end else begin
            next_ticks = ticks + `TICK_W'(1);
          end
        end
      end
      wd_trigger: begin
        if (sam_tick) begin
          next_cyc = '0;
          next_hist = hist_shift;
          if (hist_shift == `KICK_PATTERN) begin
            next_state = wd_gap;
            next_ticks = '0;
          end else if (ticks == win_ticks - `TICK_W'(1)) begin
            next_state = wd_fault;
          end else begin
            next_ticks = ticks + `TICK_W'(1);
          end
        end
      end
      wd_gap: begin
        // Samples here are dropped
        if (sam_tick) begin
          next_cyc = '0;
          next_state = wd_trigger;
          next_ticks = '0;
          next_hist = '0;
          next_mode = speed_e'(speed_sync);
        end
      end
      default: begin
        next_state = wd_reset;
        next_cyc = '0;
      end
    endcase
    if (rst_active) begin
      next_state = wd_reset;
      next_cyc = '0;
      next_ticks = '0;
      next_hist = '0;
    end
    if (next_state == wd_fault && state != wd_fault) begin
      next_cyc = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= wd_reset;
      mode <= speed_fast;
      cyc <= '0;
      ticks <= '0;
      hist <= '0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cyc <= next_cyc;
      ticks <= next_ticks;
      hist <= next_hist;
    end
  end

  // Pin drivers; a dead regulated supply cannot sink the reset line
  // Fault enable is a superset of reset enable, so the fault pin can
  // never be released while reset is pulled
  // Nothing in the watchdog path reaches the reset enable
  // Both enables are registered so the pins see no decode glitches
  always_comb begin
    next_reset_oe = rst_active & ~vfb_below_1v;
    next_fault_oe = rst_active | (state == wd_reset)
      | (state == wd_hold) | (state == wd_fault);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reset_out_n_o <= 1'b0;
      reset_out_n_oe <= 1'b1;
      wdog_fault_out_n_o <= 1'b0;
      wdog_fault_out_n_oe <= 1'b1;
    end else begin
      reset_out_n_o <= 1'b0;
      reset_out_n_oe <= next_reset_oe;
      wdog_fault_out_n_o <= 1'b0;
      wdog_fault_out_n_oe <= next_fault_oe;
    end
  end

endmodule : reset_and_window_watchdog
`default_nettype wire

// ==== testbench/rwd_props.sv ====
// Purpose: pin-level checks for the supervisor.
// Assumes: bound to the top module, delays set by the bench.
// Notes: bounds kept short so slips show quickly.
`timescale 1ns/1ps
`default_nettype none

module rwd_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Supervisor inputs
  input wire logic thresh_below,
  input wire logic vfb_below_1v,
  input wire logic vs_undervolt,
  // Pin drives
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe,
  input wire logic wdog_fault_out_n_o,
  input wire logic wdog_fault_out_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Open-drain pins may only ever pull low
  chk_drive_level: assert property (!reset_out_n_o && !wdog_fault_out_n_o)
    else $error("pin drive level not low");
  chk_vfb_release: assert property (vfb_below_1v |=> !reset_out_n_oe)
    else $error("reset pin sinks with low supply");
  chk_undervolt_reset: assert property ((vs_undervolt && !vfb_below_1v)[*3]
    |-> reset_out_n_oe) else $error("undervoltage without reset");
  chk_fault_follows_reset: assert property (reset_out_n_oe
    |-> wdog_fault_out_n_oe) else $error("reset without fault pull");
  // Fault outlasts reset by at least eight cycles
  chk_fault_hold: assert property ($fell(reset_out_n_oe) &&
    !$past(vfb_below_1v) |-> wdog_fault_out_n_oe[*8])
    else $error("fault released with reset");
  chk_fault_min_low: assert property ($rose(wdog_fault_out_n_oe)
    |=> wdog_fault_out_n_oe[*8]) else $error("fault pulse too short");
  // Reset pull needs a cause two edges back
  chk_reset_cause: assert property ($rose(reset_out_n_oe) |->
    $past(vs_undervolt, 2) || $past(thresh_below, 2) ||
    $past(vfb_below_1v, 2)) else $error("reset pulled without cause");
  chk_reset_hold: assert property ($fell(reset_out_n_oe) &&
    !$past(vfb_below_1v) |-> !$past(vs_undervolt) &&
    !$past(vs_undervolt, 2)) else $error("reset released too early");
endmodule : rwd_props

`default_nettype wire

// ==== testbench/kick_host.sv ====
// Purpose: processor model toggling the kick line.
// Assumes: half period given in clock cycles.
// Notes: line pulled low while idle.
`timescale 1ns/1ps
`default_nettype none

module kick_host (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] half_cyc,
  // Kick line
  output logic kick
);
  int cnt = 0;
  initial kick = 1'b0;
  // Square wave, three samples per level to fit any window
  always @(posedge clk) begin
    #1;
    if (!run) begin
      kick = 1'b0;
      cnt = 0;
    end else if (cnt >= int'(half_cyc) - 1) begin
      kick = ~kick;
      cnt = 0;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule : kick_host

`default_nettype wire

// ==== testbench/tb_reset_and_window_watchdog.sv ====
// Purpose: self-checking bench for the supervisor.
// Assumes: shortened delays through parameters.
// Notes: inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
  end end

module tb_reset_and_window_watchdog;
  localparam int RC = 200;
  localparam int SF = 20;
  localparam int SS = 40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic thresh_below = 1'b0;
  logic vfb_below_1v = 1'b0;
  logic vs_undervolt = 1'b0;
  logic wdog_speed_sel = 1'b0;
  logic run = 1'b0;
  logic [15:0] half_cyc = 16'h0;
  logic wdog_kick_in;
  logic reset_out_n_o;
  logic reset_out_n_oe;
  logic wdog_fault_out_n_o;
  logic wdog_fault_out_n_oe;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  reset_and_window_watchdog #(.RELEASE_CYC(RC), .SAM_FAST_CYC(SF),
    .SAM_SLOW_CYC(SS)) i_reset_and_window_watchdog (.clk(clk),
    .reset_n(reset_n), .thresh_below(thresh_below),
    .vfb_below_1v(vfb_below_1v), .vs_undervolt(vs_undervolt),
    .wdog_kick_in(wdog_kick_in), .wdog_speed_sel(wdog_speed_sel),
    .reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
    .wdog_fault_out_n_o(wdog_fault_out_n_o),
    .wdog_fault_out_n_oe(wdog_fault_out_n_oe));
  kick_host i_kick_host (.clk(clk), .run(run), .half_cyc(half_cyc),
    .kick(wdog_kick_in));

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Bounded wait for the fault pin level
  task automatic wait_fault(input logic lvl, input int lim, output int n);
    n = 0;
    while (wdog_fault_out_n_oe !== lvl && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_fault

  task automatic t_startup();
    step(1);
    `CHK("rst_oe", 1'b1, reset_out_n_oe)
    step(RC - 10);
    `CHK("rst_hold", 1'b1, reset_out_n_oe)
    step(20);
    `CHK("rst_rel", 1'b0, reset_out_n_oe)
    `CHK("flt_hold", 1'b1, wdog_fault_out_n_oe)
    step(RC - 20);
    `CHK("flt_hold2", 1'b1, wdog_fault_out_n_oe)
    step(40);
    `CHK("flt_rel", 1'b0, wdog_fault_out_n_oe)
  endtask : t_startup

  // Steady kicks keep the fault pin released
  task automatic t_kick(input int s);
    int n;
    half_cyc = 16'(3 * s);
    run = 1'b1;
    wait_fault(1'b1, 200 * s, n);
    `CHK("kick_ok", 1'b0, wdog_fault_out_n_oe)
  endtask : t_kick

  // Missing kick pulls fault for one release delay
  task automatic t_miss(input logic sel);
    int n;
    run = 1'b0;
    wait_fault(1'b1, 130 * SS, n);
    `CHK("miss_pull", 1'b1, wdog_fault_out_n_oe)
    wdog_speed_sel = sel;
    wait_fault(1'b0, RC + 10, n);
    `CHK("miss_len", 1'b1, n >= RC - 2 && n <= RC + 1)
    `CHK("rst_free", 1'b0, reset_out_n_oe)
  endtask : t_miss

  // Ignore plus one window without kicks, mode timed
  task automatic t_period(input int s);
    int n;
    wait_fault(1'b1, 130 * s, n);
    `CHK("idle_len", 1'b1, n >= 127 * s - 3 && n <= 127 * s + 3)
    wait_fault(1'b0, RC + 10, n);
  endtask : t_period

  task automatic t_supply();
    vs_undervolt = 1'b1;
    step(3);
    `CHK("uv_rst", 1'b1, reset_out_n_oe)
    `CHK("uv_flt", 1'b1, wdog_fault_out_n_oe)
    vfb_below_1v = 1'b1;
    step(2);
    `CHK("vfb_rst", 1'b0, reset_out_n_oe)
    vfb_below_1v = 1'b0;
    vs_undervolt = 1'b0;
    step(RC + 5);
    `CHK("uv_rel", 1'b0, reset_out_n_oe)
  endtask : t_supply

  // Short dip rejected, long dip pulls reset
  task automatic t_dip();
    thresh_below = 1'b1;
    step(30);
    thresh_below = 1'b0;
    step(5);
    `CHK("short_dip", 1'b0, reset_out_n_oe)
    thresh_below = 1'b1;
    step(60);
    `CHK("long_dip", 1'b1, reset_out_n_oe)
    thresh_below = 1'b0;
    step(RC + 5);
    `CHK("dip_rel", 1'b0, reset_out_n_oe)
  endtask : t_dip

  initial begin
    step(5);
    reset_n = 1'b1;
    t_startup();
    t_kick(SF);
    t_miss(1'b1);
    t_period(SS);
    t_kick(SS);
    t_miss(1'b0);
    t_period(SF);
    t_supply();
    t_dip();
    tally_and_finish();
  end
endmodule : tb_reset_and_window_watchdog

bind reset_and_window_watchdog rwd_props i_rwd_props (.clk(clk),
  .reset_n(reset_n), .thresh_below(thresh_below),
  .vfb_below_1v(vfb_below_1v), .vs_undervolt(vs_undervolt),
  .reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
  .wdog_fault_out_n_o(wdog_fault_out_n_o),
  .wdog_fault_out_n_oe(wdog_fault_out_n_oe));

`default_nettype wire
